// ===== urfc_pkg.sv
// urfc_pkg: constants, types and helpers of the receiver with flow control
// assumes one clock that ticks once per oversampling period
package urfc_pkg;

   // fifo geometry
   localparam logic [5:0] FIFO_FULL = 6'h20;
   localparam logic [5:0] NONFIFO_CAP = 6'h01;
   localparam logic [5:0] LEVEL_EMPTY = 6'h00;
   localparam logic [2:0] TAGS_NONE = 3'h0;
   localparam int TAG_PAR = 0;
   localparam int TAG_FRM = 1;
   localparam int TAG_BRK = 2;

   // oversampling selects and counts
   localparam logic [1:0] OSR_16X = 2'h0;
   localparam logic [1:0] OSR_8X = 2'h1;
   localparam logic [4:0] BIT_16X = 5'h10;
   localparam logic [4:0] BIT_8X = 5'h08;
   localparam logic [4:0] BIT_4X = 5'h04;
   localparam logic [4:0] HALF_16X = 5'h08;
   localparam logic [4:0] HALF_8X = 5'h04;
   localparam logic [4:0] HALF_4X = 5'h02;

   // character framing
   localparam logic [2:0] WL_LAST_BASE = 3'h4;
   localparam logic [3:0] WL_BASE = 4'h5;
   localparam logic [3:0] FRAME_BITS = 4'h2;
   localparam logic [11:0] TO_CHARS = 12'h004;
   localparam logic [11:0] TO_EXTRA_BITS = 12'h00c;
   localparam logic [11:0] XOFF_DELAY_CHARS = 12'h002;

   // receive trigger levels
   localparam logic [5:0] TRIG_L0 = 6'h08;
   localparam logic [5:0] TRIG_L1 = 6'h10;
   localparam logic [5:0] TRIG_L2 = 6'h18;
   localparam logic [5:0] TRIG_L3 = 6'h1e;

   // flow character register selects
   localparam logic [1:0] XSEL_XON1 = 2'h0;
   localparam logic [1:0] XSEL_XON2 = 2'h1;
   localparam logic [1:0] XSEL_XOFF1 = 2'h2;
   localparam logic [1:0] XSEL_XOFF2 = 2'h3;

   typedef enum logic [1:0] {SWF_OFF, SWF_SINGLE, SWF_DOUBLE} urfc_swf_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} urfc_rx_e;

   function automatic logic [4:0] bitLen(input logic [1:0] osr);
      return (osr == OSR_16X) ? BIT_16X : (osr == OSR_8X) ? BIT_8X : BIT_4X;
   endfunction : bitLen

   function automatic logic [4:0] halfLen(input logic [1:0] osr);
      return (osr == OSR_16X) ? HALF_16X : (osr == OSR_8X) ? HALF_8X : HALF_4X;
   endfunction : halfLen

   function automatic logic [5:0] trigLevel(input logic [1:0] sel);
      case (sel)
         2'h0: return TRIG_L0;
         2'h1: return TRIG_L1;
         2'h2: return TRIG_L2;
         default: return TRIG_L3;
      endcase
   endfunction : trigLevel

   function automatic logic [5:0] upperLevel(input logic [1:0] sel);
      return (sel == 2'h3) ? TRIG_L3 : trigLevel(sel + 2'h1);
   endfunction : upperLevel

   function automatic logic [5:0] lowerLevel(input logic [1:0] sel);
      return (sel == 2'h0) ? LEVEL_EMPTY : trigLevel(sel - 2'h1);
   endfunction : lowerLevel

   // start + data + optional parity + one stop
   function automatic logic [11:0] charClocks(input logic [1:0] wl, input logic par,
                                              input logic [1:0] osr);
      logic [11:0] bits;
      bits = 12'(WL_BASE + 4'(wl) + FRAME_BITS + 4'(par));
      return 12'(bits * 12'(bitLen(osr)));
   endfunction : charClocks

   // compare only the bits of the programmed word length
   function automatic logic charMatch(input logic [7:0] a, input logic [7:0] b,
                                      input logic [1:0] wl);
      logic [7:0] m;
      m = 8'hff >> (2'h3 - wl);
      return ((a ^ b) & m) == 8'h00;
   endfunction : charMatch

endpackage : urfc_pkg

// ===== urfc_receiver.sv
// urfc_receiver: one channel receiver, 32 entry fifo, auto rts/cts, xon/xoff
// assumes core_clk is the oversampling clock; rxPin, ctsN are asynchronous
//
// Function
// RQ1: falling edge, half bit wait, start still low
// RQ2: data and stop sampled at bit centre
// RQ3: head character errors shown as status bits 2-4
// RQ4: fifo of 32 entries, byte plus three tags
// RQ5: holding read advances pointer, errors follow head
// RQ6: fifo mode holding register shows oldest character
// RQ7: data ready interrupt per char or trigger
// RQ8: timeout after four characters plus twelve bits
// RQ9: auto rts needs enable and software rts on
// RQ10: rts low to high sets status bit 5
// RQ11: rts off one level up, on one below
// RQ12: keep receiving into fifo until full
// RQ13: auto cts enable lets cts gate transmitter
// RQ14: cts high pauses after current stop bit
// RQ15: cts deassertion sets status bit 5
// RQ16: xoff match halts transmitter after current char
// RQ17: xoff flag set, xon resumes and clears
// RQ18: reset clears xon and xoff characters
// RQ19: double mode needs two consecutive matches
// RQ20: flow characters never enter the fifo
// RQ21: auto xoff two characters after trigger crossed
// RQ22: xon sent when fill reaches lower level
// RQ23: word length from two bit field
// RQ24: software flow mode is a configuration input
`timescale 1ns/100ps
`default_nettype none

module urfc_receiver (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // serial pins
   input wire logic rxPin,
   input wire logic ctsN,
   output logic rtsN,
   // line and fifo configuration
   input wire logic [1:0] osrSel,
   input wire logic [1:0] wordLenSel,
   input wire logic parityEn,
   input wire logic parityEven,
   input wire logic fifoEnable,
   input wire logic [1:0] rxTrigSel,
   // enhanced features and modem control
   input wire logic enhancedEn,
   input wire logic autoRtsEn,
   input wire logic autoCtsEn,
   input wire logic rtsOn,
   // interrupt enables
   input wire logic rxIntEn,
   input wire logic xoffIntEn,
   input wire logic rtsIntEn,
   input wire logic ctsIntEn,
   // software flow control
   input wire urfc_pkg::urfc_swf_e swFlowMode,
   input wire logic autoXoffEn,
   input wire logic xcharWe,
   input wire logic [1:0] xcharSel,
   input wire logic [7:0] xcharData,
   // host read side
   input wire logic rhrRead,
   input wire logic intStatusRead,
   output logic [7:0] rhrData,
   output logic [2:0] lsrErr,
   output logic dataReady,
   output logic overrun,
   // interrupts and status
   output logic rxDataInt,
   output logic rxTimeoutInt,
   output logic modemFlowInt,
   output logic xoffInt,
   // transmitter coupling
   output logic txHalt,
   output logic flowSendReq,
   output logic flowSendXon,
   input wire logic flowSendAck
);
   import urfc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rxS1, rxS2, rxPrev, ctsS1, ctsS2, ctsPrev;
      urfc_rx_e rxState;
      logic [4:0] osrCnt;
      logic [2:0] bitIdx;
      logic [7:0] shiftData;
      logic parAcc, parErr, allZero;
      logic [31:0][10:0] mem;
      logic [4:0] wrPtr, rdPtr;
      logic [5:0] count;
      logic [10:0] buf0, buf1;
      logic [1:0] bufCnt;
      logic [7:0] held;
      logic heldValid, heldFlush;
      logic [7:0] xon1, xon2, xoff1, xoff2;
      logic xoffHalt, xoffFlag, specialFlag, rtsThrottle;
      logic [11:0] toCnt;
      logic toFlag;
      logic [11:0] xoffDly;
      logic xoffSent;
      logic rtsN, txHalt, flowReq, flowXon, overrun;
      logic [7:0] rhrData;
      logic [2:0] lsrErr;
      logic dataReady, rxDataInt, rxTimeoutInt;
   } urfc_state_s;

   urfc_state_s q, n;
   logic cEvt, pushReq, drain, rdFire, xoffHit, xonHit;
   logic [7:0] cData;
   logic [2:0] cTags;
   logic [10:0] pushEntry;
   logic [5:0] cap;
   logic [2:0] lastIdx;
   logic [4:0] bitLast;
   logic [11:0] toLimit, xoffLimit;

   always_comb begin
      n = q;
      cEvt = 1'b0;
      pushReq = 1'b0;
      pushEntry = '0;
      xoffHit = 1'b0;
      xonHit = 1'b0;
      cData = q.shiftData;
      cTags = TAGS_NONE;
      lastIdx = 3'(wordLenSel) + WL_LAST_BASE; // RQ23
      bitLast = bitLen(osrSel) - 5'h01;
      toLimit = 12'(charClocks(wordLenSel, parityEn, osrSel) * TO_CHARS
                + TO_EXTRA_BITS * 12'(bitLen(osrSel))) - 12'h001;
      xoffLimit = 12'(charClocks(wordLenSel, parityEn, osrSel) * XOFF_DELAY_CHARS)
                  - 12'h001;
      cap = fifoEnable ? FIFO_FULL : NONFIFO_CAP;

      // ----------------------------------------------------------------
      // synchronisers
      // ----------------------------------------------------------------
      n.rxS1 = rxPin;
      n.rxS2 = q.rxS1;
      n.rxPrev = q.rxS2;
      n.ctsS1 = ctsN;
      n.ctsS2 = q.ctsS1;
      n.ctsPrev = q.ctsS2;

      // ----------------------------------------------------------------
      // receive shifter
      // ----------------------------------------------------------------
      unique case (q.rxState)
         RX_IDLE: begin
            if (q.rxPrev && !q.rxS2) begin
               n.rxState = RX_START;
               n.osrCnt = halfLen(osrSel) - 5'h01; // RQ1
            end
         end
         RX_START: begin
            if (q.osrCnt != 5'h00) begin
               n.osrCnt = q.osrCnt - 5'h01;
            end else if (!q.rxS2) begin
               n.rxState = RX_DATA; // RQ1
               n.osrCnt = bitLast;
               n.bitIdx = 3'h0;
               n.shiftData = 8'h00;
               n.parAcc = 1'b0;
               n.parErr = 1'b0;
               n.allZero = 1'b1;
            end else begin
               n.rxState = RX_IDLE;
            end
         end
         RX_DATA: begin
            if (q.osrCnt != 5'h00) begin
               n.osrCnt = q.osrCnt - 5'h01;
            end else begin
               n.shiftData[q.bitIdx] = q.rxS2; // RQ2
               n.parAcc = q.parAcc ^ q.rxS2;
               n.allZero = q.allZero & ~q.rxS2;
               n.osrCnt = bitLast;
               n.bitIdx = q.bitIdx + 3'h1;
               if (q.bitIdx == lastIdx) begin
                  n.rxState = parityEn ? RX_PARITY : RX_STOP;
               end
            end
         end
         RX_PARITY: begin
            if (q.osrCnt != 5'h00) begin
               n.osrCnt = q.osrCnt - 5'h01;
            end else begin
               n.parErr = parityEven ? (q.parAcc ^ q.rxS2) : ~(q.parAcc ^ q.rxS2);
               n.allZero = q.allZero & ~q.rxS2;
               n.osrCnt = bitLast;
               n.rxState = RX_STOP;
            end
         end
         RX_STOP: begin
            if (q.osrCnt != 5'h00) begin
               n.osrCnt = q.osrCnt - 5'h01;
            end else begin
               cEvt = 1'b1; // RQ2
               cTags[TAG_PAR] = q.parErr;
               cTags[TAG_FRM] = ~q.rxS2;
               cTags[TAG_BRK] = q.allZero & ~q.rxS2;
               n.rxState = RX_IDLE;
            end
         end
      endcase

      // ----------------------------------------------------------------
      // flow character registers
      // ----------------------------------------------------------------
      if (xcharWe) begin
         unique case (xcharSel)
            XSEL_XON1: n.xon1 = xcharData;
            XSEL_XON2: n.xon2 = xcharData;
            XSEL_XOFF1: n.xoff1 = xcharData;
            XSEL_XOFF2: n.xoff2 = xcharData;
         endcase
      end

      // ----------------------------------------------------------------
      // software flow compare
      // ----------------------------------------------------------------
      if (q.heldFlush) begin
         pushReq = 1'b1;
         pushEntry = {TAGS_NONE, q.held};
         n.heldFlush = 1'b0;
         n.heldValid = 1'b0;
      end
      if (cEvt) begin
         case (swFlowMode) // RQ24
            SWF_SINGLE: begin
               if (charMatch(cData, q.xoff1, wordLenSel)) begin
                  xoffHit = 1'b1; // RQ16
               end else if (charMatch(cData, q.xon1, wordLenSel)) begin
                  xonHit = 1'b1;
               end else begin
                  pushReq = 1'b1;
                  pushEntry = {cTags, cData};
               end
            end
            SWF_DOUBLE: begin
               if (q.heldValid && charMatch(q.held, q.xoff1, wordLenSel)
                   && charMatch(cData, q.xoff2, wordLenSel)) begin
                  xoffHit = 1'b1; // RQ19
                  n.heldValid = 1'b0;
               end else if (q.heldValid && charMatch(q.held, q.xon1, wordLenSel)
                            && charMatch(cData, q.xon2, wordLenSel)) begin
                  xonHit = 1'b1; // RQ19
                  n.heldValid = 1'b0;
               end else begin
                  if (q.heldValid) begin
                     pushReq = 1'b1;
                     pushEntry = {TAGS_NONE, q.held};
                  end
                  n.held = cData;
                  if (charMatch(cData, q.xoff1, wordLenSel)
                      || charMatch(cData, q.xon1, wordLenSel)) begin
                     n.heldValid = 1'b1;
                  end else if (q.heldValid) begin
                     n.heldFlush = 1'b1;
                  end else begin
                     pushReq = 1'b1;
                     pushEntry = {cTags, cData};
                  end
               end
            end
            default: begin
               pushReq = 1'b1;
               pushEntry = {cTags, cData};
            end
         endcase
      end
      if (xoffHit) begin
         n.xoffHalt = 1'b1; // RQ16
         n.xoffFlag = q.xoffFlag | xoffIntEn; // RQ17
      end
      if (xonHit) begin
         n.xoffHalt = 1'b0; // RQ17
         n.xoffFlag = 1'b0;
      end

      // ----------------------------------------------------------------
      // two entry buffer and fifo
      // ----------------------------------------------------------------
      drain = (q.bufCnt != 2'h0) && (q.count < cap); // RQ12
      rdFire = rhrRead && (q.count != 6'h00);
      if (drain) begin
         n.mem[q.wrPtr] = q.buf0; // RQ4
         n.wrPtr = q.wrPtr + 5'h01;
         n.buf0 = q.buf1;
         n.bufCnt = q.bufCnt - 2'h1;
      end
      if (rdFire) begin
         n.rdPtr = q.rdPtr + 5'h01; // RQ5
         n.overrun = 1'b0;
      end
      unique case ({drain, rdFire})
         2'b10: n.count = q.count + 6'h01;
         2'b01: n.count = q.count - 6'h01;
         default: n.count = q.count;
      endcase
      if (pushReq) begin // RQ20
         if (n.bufCnt == 2'h0) begin
            n.buf0 = pushEntry;
            n.bufCnt = 2'h1;
         end else if (n.bufCnt == 2'h1) begin
            n.buf1 = pushEntry;
            n.bufCnt = 2'h2;
         end else begin
            n.overrun = 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // receive timeout
      // ----------------------------------------------------------------
      if ((q.count == 6'h00) || drain || rdFire) begin
         n.toCnt = 12'h000;
         n.toFlag = 1'b0;
      end else if (q.toCnt == toLimit) begin
         n.toFlag = 1'b1; // RQ8
      end else begin
         n.toCnt = q.toCnt + 12'h001;
      end

      // ----------------------------------------------------------------
      // hardware flow control
      // ----------------------------------------------------------------
      if (q.count >= upperLevel(rxTrigSel)) begin
         n.rtsThrottle = 1'b1; // RQ11
      end else if (q.count <= lowerLevel(rxTrigSel)) begin
         n.rtsThrottle = 1'b0;
      end
      n.rtsN = ~(rtsOn & ~(autoRtsEn & n.rtsThrottle)); // RQ9
      if (intStatusRead) begin
         n.specialFlag = 1'b0;
      end
      if (!q.rtsN && n.rtsN && rtsIntEn && enhancedEn) begin
         n.specialFlag = 1'b1; // RQ10
      end
      if (q.ctsS2 && !q.ctsPrev && ctsIntEn && enhancedEn) begin
         n.specialFlag = 1'b1; // RQ15
      end
      n.txHalt = (autoCtsEn & q.ctsS2) | n.xoffHalt; // RQ13 RQ14

      // ----------------------------------------------------------------
      // automatic xoff / xon transmission
      // ----------------------------------------------------------------
      if (flowSendAck) begin
         n.flowReq = 1'b0;
      end
      if (!autoXoffEn) begin
         n.xoffDly = 12'h000;
         n.xoffSent = 1'b0;
      end else if (!q.xoffSent) begin
         if (q.count < trigLevel(rxTrigSel)) begin
            n.xoffDly = 12'h000;
         end else if (q.xoffDly == xoffLimit) begin
            if (!q.flowReq) begin
               n.flowReq = 1'b1; // RQ21
               n.flowXon = 1'b0;
               n.xoffSent = 1'b1;
               n.xoffDly = 12'h000;
            end
         end else begin
            n.xoffDly = q.xoffDly + 12'h001;
         end
      end else if (q.count <= lowerLevel(rxTrigSel) && !q.flowReq) begin
         n.flowReq = 1'b1; // RQ22
         n.flowXon = 1'b1;
         n.xoffSent = 1'b0;
      end

      // ----------------------------------------------------------------
      // host visible outputs
      // ----------------------------------------------------------------
      n.rhrData = n.mem[n.rdPtr][7:0]; // RQ6
      n.lsrErr = (n.count != 6'h00) ? n.mem[n.rdPtr][10:8] : TAGS_NONE; // RQ3
      n.dataReady = n.count != 6'h00;
      n.rxDataInt = rxIntEn & (fifoEnable ? (n.count >= trigLevel(rxTrigSel))
                                          : (n.count != 6'h00)); // RQ7
      n.rxTimeoutInt = rxIntEn & n.toFlag;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '0; // RQ18
         q.rxS1 <= 1'b1;
         q.rxS2 <= 1'b1;
         q.rxPrev <= 1'b1;
         q.ctsS1 <= 1'b1;
         q.ctsS2 <= 1'b1;
         q.ctsPrev <= 1'b1;
         q.rtsN <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign rtsN = q.rtsN;
   assign rhrData = q.rhrData;
   assign lsrErr = q.lsrErr;
   assign dataReady = q.dataReady;
   assign overrun = q.overrun;
   assign rxDataInt = q.rxDataInt;
   assign rxTimeoutInt = q.rxTimeoutInt;
   assign modemFlowInt = q.specialFlag;
   assign xoffInt = q.xoffFlag;
   assign txHalt = q.txHalt;
   assign flowSendReq = q.flowReq;
   assign flowSendXon = q.flowXon;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   start_half_a: assert property (@(posedge core_clk) disable iff (srst) // RQ1
      (q.rxState == RX_IDLE && q.rxPrev && !q.rxS2)
      |=> (q.rxState == RX_START && q.osrCnt == halfLen(osrSel) - 5'h01))
      else $error("start wait not half a bit");

   start_reject_a: assert property (@(posedge core_clk) disable iff (srst) // RQ1
      (q.rxState == RX_START && q.osrCnt == 5'h00 && q.rxS2) |=> q.rxState == RX_IDLE)
      else $error("false start accepted");

   fifo_bound_a: assert property (@(posedge core_clk) disable iff (srst) // RQ4
      q.count <= FIFO_FULL)
      else $error("fifo count beyond depth");

   read_advance_a: assert property (@(posedge core_clk) disable iff (srst) // RQ5
      (rhrRead && q.count != 6'h00 && !drain)
      |=> (q.rdPtr == $past(q.rdPtr) + 5'h01 && q.count == $past(q.count) - 6'h01))
      else $error("read did not advance fifo");

   head_tags_a: assert property (@(posedge core_clk) disable iff (srst) // RQ3
      (q.count != 6'h00) |-> (lsrErr == q.mem[q.rdPtr][10:8] && rhrData == q.mem[q.rdPtr][7:0]))
      else $error("status tags not those of head");

   rts_off_a: assert property (@(posedge core_clk) disable iff (srst) // RQ11
      (autoRtsEn && q.count >= upperLevel(rxTrigSel)) |=> rtsN)
      else $error("rts not released at upper level");

   rts_manual_a: assert property (@(posedge core_clk) disable iff (srst) // RQ9
      (!autoRtsEn) |=> (rtsN == !$past(rtsOn)))
      else $error("rts not following software");

   rts_int_a: assert property (@(posedge core_clk) disable iff (srst) // RQ10
      ($rose(rtsN) && $past(rtsIntEn) && $past(enhancedEn)) |-> modemFlowInt)
      else $error("rts rise without status flag");

   xoff_halt_a: assert property (@(posedge core_clk) disable iff (srst) // RQ16
      (cEvt && swFlowMode == SWF_SINGLE && charMatch(cData, q.xoff1, wordLenSel))
      |=> (txHalt && !$past(pushReq)))
      else $error("xoff not halting or stored");

   xreg_reset_a: assert property (@(posedge core_clk) // RQ18
      $past(srst) |-> (q.xon1 == 8'h00 && q.xon2 == 8'h00 && q.xoff1 == 8'h00
                       && q.xoff2 == 8'h00))
      else $error("flow characters not cleared");

endmodule : urfc_receiver

`default_nettype wire

// ===== urfc_remote_uart.sv
// urfc_remote_uart: far-end serial transmitter feeding the receive pin
// assumes the receiver's tick clock; idle line is mark (high)
`timescale 1ns/100ps
`default_nettype none

module urfc_remote_uart (
   // clock
   input wire logic core_clk,
   // character request
   input wire logic sendGo,
   input wire logic [7:0] sendByte,
   input wire logic badStop,
   input wire logic ignoreRts,
   // framing
   input wire logic [4:0] bitTicks,
   input wire logic [3:0] dataBits,
   // line
   input wire logic rtsN,
   output logic txLine,
   output logic busy
);
   logic [3:0] bitIdx;
   logic [4:0] tick;
   initial begin
      txLine = 1'b1;
      busy = 1'b0;
      bitIdx = 4'h0;
      tick = 5'h00;
   end
   always @(posedge core_clk) begin
      if (!busy) begin
         // a held-off character waits; one in flight always completes
         if (sendGo && (!rtsN || ignoreRts)) begin
            busy <= 1'b1;
            txLine <= 1'b0;
            bitIdx <= 4'h0;
            tick <= 5'h01;
         end
      end else if (tick != bitTicks) begin
         tick <= tick + 5'h01;
      end else if (bitIdx == dataBits + 4'h1) begin
         busy <= 1'b0;
         txLine <= 1'b1;
      end else begin
         tick <= 5'h01;
         bitIdx <= bitIdx + 4'h1;
         txLine <= (bitIdx == dataBits) ? ~badStop : sendByte[bitIdx[2:0]];
      end
   end
endmodule : urfc_remote_uart

`default_nettype wire

// ===== urfc_receiver_test.sv
// urfc_receiver_test: self-checking bench of the receiver
// assumes urfc_pkg, urfc_receiver and urfc_remote_uart
`timescale 1ns/100ps
`default_nettype none

module urfc_receiver_test;
   import urfc_pkg::*;
   typedef struct packed {
      logic [1:0] osr;
      logic [1:0] wl;
      logic [7:0] dat;
      logic bad;
      logic [7:0] expD;
      logic [2:0] expE;
   } urfc_row_s;
   urfc_row_s rows [7] = '{'{2'h0, 2'h3, 8'h5a, 1'b0, 8'h5a, 3'h0},
      '{2'h1, 2'h3, 8'ha5, 1'b0, 8'ha5, 3'h0}, '{2'h2, 2'h3, 8'h3c, 1'b0, 8'h3c, 3'h0},
      '{2'h2, 2'h0, 8'hf3, 1'b0, 8'h13, 3'h0}, '{2'h2, 2'h1, 8'hff, 1'b0, 8'h3f, 3'h0},
      '{2'h2, 2'h2, 8'h81, 1'b0, 8'h01, 3'h0}, '{2'h2, 2'h3, 8'h6e, 1'b1, 8'h6e, 3'h2}};
   logic core_clk, srst, ctsN, rtsN, enhancedEn, autoRtsEn, autoCtsEn, rtsOn, rxIntEn;
   logic xoffIntEn, rtsIntEn, ctsIntEn, xcharWe, rhrRead, intStatusRead, dataReady, overrun;
   logic rxDataInt, rxTimeoutInt, modemFlowInt, xoffInt, txHalt, sendGo, badStop, glitchN;
   logic ignoreRts, txLine, busy, fifoEnable;
   logic [1:0] osrSel, wordLenSel, rxTrigSel, xcharSel;
   logic [7:0] xcharData, rhrData, sendByte;
   logic [2:0] lsrErr;
   urfc_swf_e swFlowMode;
   int numErrors = 0;
   int numChecks = 0;
   wire logic rxPin = txLine & glitchN;
   wire logic [4:0] bitTicks = (osrSel == 2'h0) ? 5'h10 : (osrSel == 2'h1) ? 5'h08 : 5'h04;

   urfc_receiver dut_u (.core_clk(core_clk), .srst(srst), .rxPin(rxPin), .ctsN(ctsN),
      .rtsN(rtsN), .osrSel(osrSel), .wordLenSel(wordLenSel), .parityEn(1'b0),
      .parityEven(1'b0), .fifoEnable(fifoEnable), .rxTrigSel(rxTrigSel),
      .enhancedEn(enhancedEn), .autoRtsEn(autoRtsEn), .autoCtsEn(autoCtsEn), .rtsOn(rtsOn),
      .rxIntEn(rxIntEn), .xoffIntEn(xoffIntEn), .rtsIntEn(rtsIntEn), .ctsIntEn(ctsIntEn),
      .swFlowMode(swFlowMode), .autoXoffEn(1'b0), .xcharWe(xcharWe), .xcharSel(xcharSel),
      .xcharData(xcharData), .rhrRead(rhrRead), .intStatusRead(intStatusRead),
      .rhrData(rhrData), .lsrErr(lsrErr), .dataReady(dataReady), .overrun(overrun),
      .rxDataInt(rxDataInt), .rxTimeoutInt(rxTimeoutInt), .modemFlowInt(modemFlowInt),
      .xoffInt(xoffInt), .txHalt(txHalt), .flowSendReq(), .flowSendXon(),
      .flowSendAck(1'b0));
   urfc_remote_uart far_u (.core_clk(core_clk), .sendGo(sendGo), .sendByte(sendByte),
      .badStop(badStop), .ignoreRts(ignoreRts), .bitTicks(bitTicks),
      .dataBits(4'(wordLenSel) + 4'h5), .rtsN(rtsN), .txLine(txLine), .busy(busy));

   // ----
   // tasks
   // ----
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic sendChar(input logic [7:0] b, input logic bad);
      sendByte = b;
      badStop = bad;
      sendGo = 1'b1;
      wait (busy);
      @(negedge core_clk) sendGo = 1'b0;
      for (int i = 0; i < 900 && busy; i++) @(negedge core_clk);
      repeat (6) @(negedge core_clk);
   endtask : sendChar
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk) s = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask : pulse
   task automatic testDone();
      if (numErrors == 0 && numChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : testDone

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      numErrors++;
      testDone();
   end
   initial begin
      {srst, ctsN, enhancedEn, autoRtsEn, autoCtsEn, rtsOn, rxIntEn, xoffIntEn} = 8'h84;
      {rtsIntEn, ctsIntEn, xcharWe, rhrRead, intStatusRead, sendGo, badStop} = 7'h00;
      {glitchN, ignoreRts, fifoEnable, osrSel, wordLenSel, rxTrigSel, xcharSel} = 11'h500;
      {xcharData, sendByte} = 16'h0000;
      swFlowMode = SWF_OFF;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      foreach (rows[i]) begin
         osrSel = rows[i].osr;
         wordLenSel = rows[i].wl;
         sendChar(rows[i].dat, rows[i].bad);
         check("dataReady", 8'(dataReady), 8'h01);
         check("rhrData", rhrData, rows[i].expD);
         check("lsrErr", 8'(lsrErr), 8'(rows[i].expE));
         pulse(rhrRead);
         check("lsrErr", 8'(lsrErr), 8'h00);
      end
      // short low pulse on the line must not start a character
      osrSel = 2'h0;
      glitchN = 1'b0;
      repeat (3) @(negedge core_clk);
      glitchN = 1'b1;
      repeat (200) @(negedge core_clk);
      check("dataReady", 8'(dataReady), 8'h00);
      // fill with remote ignoring rts, then drain
      {osrSel, wordLenSel} = 4'ha;
      {enhancedEn, autoRtsEn, rtsOn, rxIntEn, rtsIntEn, ignoreRts} = 6'h3f;
      for (int k = 0; k < 32; k++) begin
         sendChar(8'(k + 8'h40), 1'b0);
         if (k == 6) check("rxDataInt", 8'(rxDataInt), 8'h00);
         if (k == 7) check("rxDataInt", 8'(rxDataInt), 8'h01);
         if (k == 14) check("rtsN", 8'(rtsN), 8'h00);
         if (k == 15) check("rtsN", 8'(rtsN), 8'h01);
         if (k == 15) check("modemFlowInt", 8'(modemFlowInt), 8'h01);
      end
      check("overrun", 8'(overrun), 8'h00);
      check("rxTimeoutInt", 8'(rxTimeoutInt), 8'h00);
      repeat (200) @(negedge core_clk);
      check("rxTimeoutInt", 8'(rxTimeoutInt), 8'h01);
      for (int k = 0; k < 32; k++) begin
         check("rhrData", rhrData, 8'(k + 8'h40));
         pulse(rhrRead);
         if (k == 30) check("rtsN", 8'(rtsN), 8'h01);
      end
      check("rtsN", 8'(rtsN), 8'h00);
      check("dataReady", 8'(dataReady), 8'h00);
      // xoff then xon, xon left at its reset value
      {swFlowMode, xoffIntEn, xcharSel, xcharData} = {SWF_SINGLE, 1'b1, XSEL_XOFF1, 8'h13};
      pulse(xcharWe);
      sendChar(8'h13, 1'b0);
      check("xoffInt", 8'(xoffInt), 8'h01);
      check("txHalt", 8'(txHalt), 8'h01);
      check("dataReady", 8'(dataReady), 8'h00);
      sendChar(8'h00, 1'b0);
      check("txHalt", 8'(txHalt), 8'h00);
      check("xoffInt", 8'(xoffInt), 8'h00);
      // cts pause and resume
      pulse(intStatusRead);
      {autoCtsEn, ctsIntEn, ctsN} = 3'h7;
      repeat (6) @(negedge core_clk);
      check("txHalt", 8'(txHalt), 8'h01);
      check("modemFlowInt", 8'(modemFlowInt), 8'h01);
      ctsN = 1'b0;
      repeat (6) @(negedge core_clk);
      check("txHalt", 8'(txHalt), 8'h00);
      // second reset wipes the programmed xoff character
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      check("rtsN", 8'(rtsN), 8'h01);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      sendChar(8'h13, 1'b0);
      check("rhrData", rhrData, 8'h13);
      testDone();
   end
endmodule : urfc_receiver_test

`default_nettype wire
